// ### tb/atm_axi_cpu.sv
// Processor model that drives the timer's AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module atm_axi_cpu (
    input wire logic clk, // Clock.
    output logic awvalid, // AW valid.
    input wire logic awready, // AW ready.
    output logic [7:0] awaddr, // AW address.
    output logic wvalid, // W valid.
    input wire logic wready, // W ready.
    output logic [31:0] wdata, // W data.
    output logic [3:0] wstrb, // W strobes.
    input wire logic bvalid, // B valid.
    output logic bready, // B ready.
    input wire logic [1:0] bresp, // B response.
    output logic arvalid, // AR valid.
    input wire logic arready, // AR ready.
    output logic [7:0] araddr, // AR address.
    input wire logic rvalid, // R valid.
    output logic rready, // R ready.
    input wire logic [31:0] rdata, // R data.
    input wire logic [1:0] rresp // R response.
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
    end

    // Released lines show the inverse, so stale values never look valid.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        forever begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : atm_axi_cpu

`default_nettype wire

// ### tb/atm_status_irq_sva.sv
// Bus handshake and response checks of the timer status block.
`include "atm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module atm_status_irq_sva (
    input wire logic SYS_CLK, // Clock.
    input wire logic RST_N, // Reset, active low.
    input wire logic S_AXI_AWVALID, // AW valid.
    input wire logic S_AXI_AWREADY, // AW ready.
    input wire logic [7:0] S_AXI_AWADDR, // AW address.
    input wire logic S_AXI_WVALID, // W valid.
    input wire logic S_AXI_WREADY, // W ready.
    input wire logic S_AXI_BVALID, // B valid.
    input wire logic S_AXI_BREADY, // B ready.
    input wire logic [1:0] S_AXI_BRESP, // B response.
    input wire logic S_AXI_ARVALID, // AR valid.
    input wire logic S_AXI_ARREADY, // AR ready.
    input wire logic [7:0] S_AXI_ARADDR, // AR address.
    input wire logic S_AXI_RVALID, // R valid.
    input wire logic S_AXI_RREADY, // R ready.
    input wire logic [31:0] S_AXI_RDATA, // R data.
    input wire logic [1:0] S_AXI_RRESP, // R response.
    input wire logic IRQ, // Interrupt request.
    input wire logic WAKEUP // Wake-up pulse.
);
    logic aw_bad;

    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // Marks a write whose address lies beyond the map.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_bad <= 1'b0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_bad <= S_AXI_AWADDR > `ATM_OFF_CLOCK;
        end
    end

    property p_b_after_both; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID; endproperty
    a_b_after_both: assert property (p_b_after_both) else $error("write response late");
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_no_accept_b; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_no_accept_b: assert property (p_no_accept_b) else $error("write accepted during response");
    property p_r_next; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_r_next: assert property (p_r_next) else $error("read data late");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_rd_bad; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > `ATM_OFF_CLOCK
        |=> S_AXI_RRESP == `ATM_RESP_SLVERR && S_AXI_RDATA == 32'h0; endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
    property p_wr_bad; $rose(S_AXI_BVALID) && aw_bad |-> S_AXI_BRESP == `ATM_RESP_SLVERR; endproperty
    a_wr_bad: assert property (p_wr_bad) else $error("unmapped write not refused");
    property p_rd_status; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `ATM_OFF_STATUS
        |=> S_AXI_RRESP == `ATM_RESP_OKAY; endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read refused");

    c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_wake: cover property (WAKEUP);
    c_irq: cover property ($rose(IRQ));
endmodule : atm_status_irq_sva

bind atm_status_irq atm_status_irq_sva i_sva (.SYS_CLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP, .IRQ, .WAKEUP);

`default_nettype wire

// ### tb/atm_status_irq_test.sv
// Self-checking testbench of the timer status block.
`include "atm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module atm_status_irq_test;
    // A long sync delay keeps back-to-back accesses inside the busy window.
    localparam int SYNC = 16;
    localparam logic [7:0] RST_OFFS [5] = '{8'h08, 8'h18, 8'h1c, 8'h20, 8'h24};
    localparam logic [31:0] ones = 32'hffff_ffff;
    logic clk, rst_n, tick, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, wake;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, count;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_fail = 0, num_checks = 0, n_wake = 0, cyc = 0;

    atm_status_irq #(.SYNC_CYCLES(SYNC), .CLK_SYNC_CYCLES(SYNC)) i_dut (.SYS_CLK(clk), .RST_N(rst_n),
        .PRESC_TICK(tick), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .IRQ(irq), .WAKEUP(wake), .COUNT(count));
    atm_axi_cpu i_cpu (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        tick = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    end

    always @(posedge clk) begin
        cyc++;
        if (wake === 1'b1) n_wake++;
        if (cyc == 30000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit w = 0);
        logic [1:0] r;
        i_cpu.wr(a, d, r);
        chk("bresp", a > `ATM_OFF_CLOCK ? `ATM_RESP_SLVERR : `ATM_RESP_OKAY, r);
        if (w) idle();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        i_cpu.rd(a, d, r);
        chk($sformatf("reg %h", a), e & m, d & m);
        chk("rresp", a > `ATM_OFF_CLOCK ? `ATM_RESP_SLVERR : `ATM_RESP_OKAY, r);
    endtask : rd

    task automatic idle;
        logic [31:0] d;
        logic [1:0] r;
        repeat (50) begin
            i_cpu.rd(`ATM_OFF_STATUS, d, r);
            if (!d[`ATM_BIT_BUSY] && !d[`ATM_BIT_CLOCK_BUSY_FLAG]) break;
        end
        chk("idle", 32'h0, d & 32'h1100_0000);
    endtask : idle

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : ticks

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int w0;
        @(posedge rst_n);
        @(posedge clk);
        foreach (RST_OFFS[i]) rd(RST_OFFS[i], ones, `ATM_RESET_WORD);
        wr(`ATM_OFF_IRQ_SET, `ATM_EVENT_MASK);
        rd(`ATM_OFF_IRQ_STATE, ones, `ATM_EVENT_MASK);
        wr(`ATM_OFF_IRQ_CLEAR, 32'h0);
        rd(`ATM_OFF_IRQ_STATE, ones, `ATM_EVENT_MASK);
        wr(`ATM_OFF_IRQ_CLEAR, 32'h301);
        rd(`ATM_OFF_IRQ_STATE, ones, 32'h2303_0000);
        wr(`ATM_OFF_IRQ_CLEAR, ones);
        rd(`ATM_OFF_IRQ_STATE, ones, 32'h0);
        wr(`ATM_OFF_CLOCK, 32'h1);
        rd(`ATM_OFF_STATUS, 32'h1000_0000, 32'h1000_0000);
        idle();
        rd(`ATM_OFF_STATUS, 32'h3000_0000, 32'h2000_0000);
        wr(`ATM_OFF_ALARM0, 32'h5);
        wr(`ATM_OFF_ALARM0, 32'h9);
        wr(`ATM_OFF_STATUS_CLEAR, 32'h2000_0000);
        rd(`ATM_OFF_ALARM0, ones, 32'h0);
        idle();
        rd(`ATM_OFF_STATUS, 32'h3300_0000, 32'h2200_0000);
        rd(`ATM_OFF_ALARM0, ones, 32'h5);
        wr(`ATM_OFF_ALARM1, 32'ha5c3_0f1e, 1);
        rd(`ATM_OFF_ALARM1, ones, 32'ha5c3_0f1e);
        wr(`ATM_OFF_STATUS_CLEAR, 32'h2000_0000, 1);
        rd(`ATM_OFF_STATUS, 32'h2000_0000, 32'h0);
        wr(`ATM_OFF_IRQ_SET, 32'h0200_0000);
        repeat (2) @(posedge clk);
        chk("irq", 1, irq);
        wr(`ATM_OFF_IRQ_CLEAR, 32'h0200_0000);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        wr(`ATM_OFF_IRQ_SET, 32'h100);
        wr(`ATM_OFF_WAKEUP, 32'h100, 1);
        wr(`ATM_OFF_CONTROL, 32'h103, 1);
        w0 = n_wake;
        ticks(5);
        chk("wake", w0 + 1, n_wake);
        chk("irq", 1, irq);
        chk("count", 0, count);
        rd(`ATM_OFF_STATUS, 32'h100, 32'h100);
        wr(`ATM_OFF_STATUS_CLEAR, 32'h100, 1);
        rd(`ATM_OFF_STATUS, 32'h100, 32'h0);
        chk("irq", 0, irq);
        wr(`ATM_OFF_PERIODIC1, 32'h2, 1);
        wr(`ATM_OFF_CONTROL, 32'h3, 1);
        wr(`ATM_OFF_WAKEUP, 32'h1_0000, 1);
        wr(`ATM_OFF_STATUS_CLEAR, 32'h3_0000, 1);
        w0 = n_wake;
        ticks(1);
        rd(`ATM_OFF_STATUS, 32'h3_0000, 32'h1_0000);
        ticks(3);
        rd(`ATM_OFF_STATUS, 32'h3_0000, 32'h3_0000);
        chk("wake", w0 + 2, n_wake);
        wr(`ATM_OFF_COUNTER, 32'hffff_fffe, 1);
        wr(`ATM_OFF_WAKEUP, 32'h1, 1);
        wr(`ATM_OFF_STATUS_CLEAR, 32'h1, 1);
        w0 = n_wake;
        ticks(2);
        rd(`ATM_OFF_STATUS, 32'h1, 32'h1);
        chk("wake", w0 + 1, n_wake);
        chk("count", 0, count);
        wr(8'h48, 32'h1);
        rd(8'h44, ones, 32'h0);
        give_verdict();
    end
endmodule : atm_status_irq_test

`default_nettype wire

// ### verilog/atm_pkg.sv
// Types shared by the timer status block.
package atm_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } atm_write_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } atm_read_t;

    typedef enum logic [1:0] {
        ATM_WR_IDLE,
        ATM_WR_RESP
    } atm_wr_state_t;
endpackage : atm_pkg

// ### verilog/atm_regs.svh
// Register offsets, field positions, reset values and timing counts of the timer status block.
`ifndef ATM_REGS_SVH
`define ATM_REGS_SVH

`define ATM_OFF_CONTROL 8'h00
`define ATM_OFF_COUNTER 8'h04
`define ATM_OFF_STATUS 8'h08
`define ATM_OFF_STATUS_CLEAR 8'h0c
`define ATM_OFF_IRQ_SET 8'h10
`define ATM_OFF_IRQ_CLEAR 8'h14
`define ATM_OFF_IRQ_STATE 8'h18
`define ATM_OFF_WAKEUP 8'h1c
`define ATM_OFF_ALARM0 8'h20
`define ATM_OFF_ALARM1 8'h24
`define ATM_OFF_PERIODIC0 8'h30
`define ATM_OFF_PERIODIC1 8'h34
`define ATM_OFF_CLOCK 8'h40

`define ATM_BIT_OVF 0
`define ATM_BIT_ALARM0 8
`define ATM_BIT_ALARM1 9
`define ATM_BIT_PER0 16
`define ATM_BIT_PER1 17
`define ATM_BIT_BUSY 24
`define ATM_BIT_READY 25
`define ATM_BIT_CLOCK_BUSY_FLAG 28
`define ATM_BIT_CLOCK_READY_FLAG 29
`define ATM_BIT_CA0 8
`define ATM_BIT_CA1 9
`define ATM_BIT_EN 0
`define ATM_BIT_PCLR 1
`define ATM_BIT_CEN 0

`define ATM_EVENT_MASK 32'h2303_0301
`define ATM_WAKE_MASK 32'h0003_0301
`define ATM_RESET_WORD 32'h0000_0000
`define ATM_INTERVAL_SELECT_W 5

`define ATM_SYNC_TIME_NS 300
`define ATM_CLK_PERIOD_NS 100
`define ATM_SYNC_CYCLES ((`ATM_SYNC_TIME_NS + `ATM_CLK_PERIOD_NS - 1) / `ATM_CLK_PERIOD_NS)
`define ATM_CLK_SYNC_TIME_NS 500
`define ATM_CLK_SYNC_CYCLES ((`ATM_CLK_SYNC_TIME_NS + `ATM_CLK_PERIOD_NS - 1) / `ATM_CLK_PERIOD_NS)

`define ATM_RESP_OKAY 2'b00
`define ATM_RESP_SLVERR 2'b10

`endif

// ### verilog/atm_status_irq.sv
// Status, interrupt mask, wake-up and alarm logic of the asynchronous timer with its AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "atm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module atm_status_irq #(
    parameter int PRESC_W = 32,
    parameter int SYNC_CYCLES = `ATM_SYNC_CYCLES,
    parameter int CLK_SYNC_CYCLES = `ATM_CLK_SYNC_CYCLES
) (
    input wire logic SYS_CLK, // System clock.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic PRESC_TICK, // One-cycle pulse advancing the prescaler.
    input wire logic S_AXI_AWVALID, // Write address valid.
    output logic S_AXI_AWREADY, // Write address ready.
    input wire logic [7:0] S_AXI_AWADDR, // Write address.
    input wire logic S_AXI_WVALID, // Write data valid.
    output logic S_AXI_WREADY, // Write data ready.
    input wire logic [31:0] S_AXI_WDATA, // Write data.
    input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
    output logic S_AXI_BVALID, // Write response valid.
    input wire logic S_AXI_BREADY, // Write response ready.
    output logic [1:0] S_AXI_BRESP, // Write response.
    input wire logic S_AXI_ARVALID, // Read address valid.
    output logic S_AXI_ARREADY, // Read address ready.
    input wire logic [7:0] S_AXI_ARADDR, // Read address.
    output logic S_AXI_RVALID, // Read data valid.
    input wire logic S_AXI_RREADY, // Read data ready.
    output logic [31:0] S_AXI_RDATA, // Read data.
    output logic [1:0] S_AXI_RRESP, // Read response.
    output logic IRQ, // Interrupt request, active high.
    output logic WAKEUP, // Wake-up pulse to the processor.
    output logic [31:0] COUNT // Current counter value.
);

    // ----------------------------------------------------------------
    // Write channel capture
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    atm_pkg::atm_write_t wr;
    atm_pkg::atm_wr_state_t wr_state;
    logic [1:0] bresp;
    logic wr_fire;

    assign S_AXI_AWREADY = (wr_state == atm_pkg::ATM_WR_IDLE) && !aw_held;
    assign S_AXI_WREADY = (wr_state == atm_pkg::ATM_WR_IDLE) && !w_held;
    assign S_AXI_BVALID = (wr_state == atm_pkg::ATM_WR_RESP);
    assign S_AXI_BRESP = bresp;

    wire logic aw_now = aw_held || (S_AXI_AWVALID && S_AXI_AWREADY);
    wire logic w_now = w_held || (S_AXI_WVALID && S_AXI_WREADY);
    wire logic [7:0] wr_addr = aw_held ? wr.addr : S_AXI_AWADDR;
    wire logic [31:0] wr_data = w_held ? wr.data : S_AXI_WDATA;
    wire logic [3:0] wr_strb = w_held ? wr.strb : S_AXI_WSTRB;
    assign wr_fire = (wr_state == atm_pkg::ATM_WR_IDLE) && aw_now && w_now;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `ATM_OFF_CONTROL, `ATM_OFF_COUNTER, `ATM_OFF_STATUS, `ATM_OFF_STATUS_CLEAR,
            `ATM_OFF_IRQ_SET, `ATM_OFF_IRQ_CLEAR, `ATM_OFF_IRQ_STATE, `ATM_OFF_WAKEUP,
            `ATM_OFF_ALARM0, `ATM_OFF_ALARM1, `ATM_OFF_PERIODIC0, `ATM_OFF_PERIODIC1,
            `ATM_OFF_CLOCK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr <= '0;
            wr_state <= atm_pkg::ATM_WR_IDLE;
            bresp <= `ATM_RESP_OKAY;
        end else begin
            case (wr_state)
                atm_pkg::ATM_WR_IDLE: begin
                    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                        wr.addr <= S_AXI_AWADDR;
                    end
                    if (S_AXI_WVALID && S_AXI_WREADY) begin
                        wr.data <= S_AXI_WDATA;
                        wr.strb <= S_AXI_WSTRB;
                    end
                    if (wr_fire) begin
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        wr_state <= atm_pkg::ATM_WR_RESP;
                        bresp <= is_mapped(wr_addr) ? `ATM_RESP_OKAY : `ATM_RESP_SLVERR;
                    end else begin
                        aw_held <= aw_now;
                        w_held <= w_now;
                    end
                end
                atm_pkg::ATM_WR_RESP: begin
                    if (S_AXI_BREADY) begin
                        wr_state <= atm_pkg::ATM_WR_IDLE;
                    end
                end
                default: wr_state <= atm_pkg::ATM_WR_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    logic busy;
    logic clk_busy;
    wire logic [31:0] wmask = strb_mask(wr_strb);
    wire logic [31:0] wbits = wr_data & wmask;
    // Synchronised writes are dropped silently while busy; software must wait for ready first.
    wire logic sync_ok = wr_fire && !busy;
    wire logic wr_control = sync_ok && (wr_addr == `ATM_OFF_CONTROL);
    wire logic wr_counter = sync_ok && (wr_addr == `ATM_OFF_COUNTER);
    wire logic wr_sclear = sync_ok && (wr_addr == `ATM_OFF_STATUS_CLEAR);
    wire logic wr_wake = sync_ok && (wr_addr == `ATM_OFF_WAKEUP);
    wire logic wr_al0 = sync_ok && (wr_addr == `ATM_OFF_ALARM0);
    wire logic wr_al1 = sync_ok && (wr_addr == `ATM_OFF_ALARM1);
    wire logic wr_per0 = sync_ok && (wr_addr == `ATM_OFF_PERIODIC0);
    wire logic wr_per1 = sync_ok && (wr_addr == `ATM_OFF_PERIODIC1);
    wire logic wr_clock = wr_fire && !clk_busy && (wr_addr == `ATM_OFF_CLOCK);
    wire logic wr_iset = wr_fire && (wr_addr == `ATM_OFF_IRQ_SET);
    wire logic wr_iclr = wr_fire && (wr_addr == `ATM_OFF_IRQ_CLEAR);
    wire logic wr_sync_reg = wr_control || wr_counter || wr_sclear || wr_wake
                             || wr_al0 || wr_al1 || wr_per0 || wr_per1;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [31:0] timer_control;
    logic [31:0] wakeup_enable;
    logic [31:0] alarm_compare_0;
    logic [31:0] alarm_compare_1;
    logic [`ATM_INTERVAL_SELECT_W-1:0] interval_select_0;
    logic [`ATM_INTERVAL_SELECT_W-1:0] interval_select_1;
    logic clock_enable_bit;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            timer_control <= `ATM_RESET_WORD;
            wakeup_enable <= `ATM_RESET_WORD;
            alarm_compare_0 <= `ATM_RESET_WORD;
            alarm_compare_1 <= `ATM_RESET_WORD;
            interval_select_0 <= '0;
            interval_select_1 <= '0;
            clock_enable_bit <= 1'b0;
        end else begin
            if (wr_control) begin
                timer_control <= (timer_control & ~wmask) | (wbits & ~(32'h1 << `ATM_BIT_PCLR));
            end
            if (wr_wake) begin
                wakeup_enable <= (wakeup_enable & ~wmask) | (wbits & `ATM_WAKE_MASK);
            end
            if (wr_al0) begin
                alarm_compare_0 <= (alarm_compare_0 & ~wmask) | wbits;
            end
            if (wr_al1) begin
                alarm_compare_1 <= (alarm_compare_1 & ~wmask) | wbits;
            end
            if (wr_per0 && wr_strb[0]) begin
                interval_select_0 <= wr_data[`ATM_INTERVAL_SELECT_W-1:0];
            end
            if (wr_per1 && wr_strb[0]) begin
                interval_select_1 <= wr_data[`ATM_INTERVAL_SELECT_W-1:0];
            end
            if (wr_clock && wr_strb[0]) begin
                clock_enable_bit <= wr_data[`ATM_BIT_CEN];
            end
        end
    end

    // ----------------------------------------------------------------
    // Busy timers standing in for the asynchronous synchroniser delay
    // ----------------------------------------------------------------
    logic [7:0] busy_cnt;
    logic [7:0] clk_busy_cnt;
    logic busy_q;
    logic clk_busy_q;
    assign busy = (busy_cnt != 8'h00);
    assign clk_busy = (clk_busy_cnt != 8'h00);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_cnt <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
            if (wr_sync_reg) begin
                busy_cnt <= 8'(SYNC_CYCLES);
            end else if (busy) begin
                busy_cnt <= busy_cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_busy_cnt <= 8'h00;
            clk_busy_q <= 1'b0;
        end else begin
            clk_busy_q <= clk_busy;
            if (wr_clock && wr_strb[0]) begin
                clk_busy_cnt <= 8'(CLK_SYNC_CYCLES);
            end else if (clk_busy) begin
                clk_busy_cnt <= clk_busy_cnt - 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Prescaler and counter
    // ----------------------------------------------------------------
    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] presc_q;
    logic [31:0] counter;
    wire logic run = timer_control[`ATM_BIT_EN] && clock_enable_bit;
    wire logic hit0 = run && (counter == alarm_compare_0);
    wire logic hit1 = run && (counter == alarm_compare_1);
    wire logic hit0_rise;
    wire logic hit1_rise;
    logic hit0_q;
    logic hit1_q;
    assign hit0_rise = hit0 && !hit0_q;
    assign hit1_rise = hit1 && !hit1_q;
    wire logic ovf_evt = run && PRESC_TICK && (counter == 32'hffff_ffff);
    wire logic per0_evt = presc[interval_select_0] && !presc_q[interval_select_0];
    wire logic per1_evt = presc[interval_select_1] && !presc_q[interval_select_1];
    assign COUNT = counter;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            presc <= '0;
            presc_q <= '0;
            counter <= 32'h0000_0000;
            hit0_q <= 1'b0;
            hit1_q <= 1'b0;
        end else begin
            presc_q <= presc;
            hit0_q <= hit0;
            hit1_q <= hit1;
            if (wr_control && wr_strb[0] && wr_data[`ATM_BIT_PCLR]) begin
                presc <= '0;
            end else if (run && PRESC_TICK) begin
                presc <= presc + 1'b1;
            end
            if (wr_counter) begin
                counter <= (counter & ~wmask) | wbits;
            end else if ((hit0_rise && timer_control[`ATM_BIT_CA0])
                         || (hit1_rise && timer_control[`ATM_BIT_CA1])) begin
                counter <= 32'h0000_0000;
            end else if (run && PRESC_TICK) begin
                counter <= counter + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags, mask, interrupt and wake-up
    // ----------------------------------------------------------------
    logic [31:0] event_status;
    logic [31:0] irq_enable_state;
    logic [31:0] set_bits;
    always_comb begin
        set_bits = 32'h0000_0000;
        set_bits[`ATM_BIT_OVF] = ovf_evt;
        set_bits[`ATM_BIT_ALARM0] = hit0_rise;
        set_bits[`ATM_BIT_ALARM1] = hit1_rise;
        set_bits[`ATM_BIT_PER0] = per0_evt;
        set_bits[`ATM_BIT_PER1] = per1_evt;
        set_bits[`ATM_BIT_READY] = busy_q && !busy;
        set_bits[`ATM_BIT_CLOCK_READY_FLAG] = clk_busy_q && !clk_busy;
    end

    // A new event in the same cycle as its clear keeps the flag set.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            event_status <= `ATM_RESET_WORD;
        end else begin
            event_status <= ((event_status & ~(wr_sclear ? (wbits & `ATM_EVENT_MASK) : 32'h0))
                             | set_bits) & `ATM_EVENT_MASK;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_enable_state <= `ATM_RESET_WORD;
        end else begin
            irq_enable_state <= ((irq_enable_state | (wr_iset ? wbits : 32'h0))
                                 & ~(wr_iclr ? wbits : 32'h0)) & `ATM_EVENT_MASK;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
            WAKEUP <= 1'b0;
        end else begin
            IRQ <= |(event_status & irq_enable_state);
            WAKEUP <= |(set_bits & wakeup_enable & `ATM_WAKE_MASK);
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    atm_pkg::atm_read_t rd;
    logic rvalid;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rd.data;
    assign S_AXI_RRESP = rd.resp;

    function automatic logic [31:0] gate(input logic b, input logic [31:0] v);
        gate = b ? 32'h0000_0000 : v;
    endfunction : gate

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid <= 1'b0;
            rd <= '0;
        end else if (S_AXI_ARVALID && !rvalid) begin
            rvalid <= 1'b1;
            rd.resp <= is_mapped(S_AXI_ARADDR) ? `ATM_RESP_OKAY : `ATM_RESP_SLVERR;
            case (S_AXI_ARADDR)
                `ATM_OFF_CONTROL: rd.data <= gate(busy, timer_control);
                `ATM_OFF_COUNTER: rd.data <= gate(busy, counter);
                `ATM_OFF_STATUS: rd.data <= event_status | (32'(busy) << `ATM_BIT_BUSY)
                                            | (32'(clk_busy) << `ATM_BIT_CLOCK_BUSY_FLAG);
                `ATM_OFF_IRQ_STATE: rd.data <= irq_enable_state;
                `ATM_OFF_WAKEUP: rd.data <= gate(busy, wakeup_enable);
                `ATM_OFF_ALARM0: rd.data <= gate(busy, alarm_compare_0);
                `ATM_OFF_ALARM1: rd.data <= gate(busy, alarm_compare_1);
                `ATM_OFF_PERIODIC0: rd.data <= gate(busy, 32'(interval_select_0));
                `ATM_OFF_PERIODIC1: rd.data <= gate(busy, 32'(interval_select_1));
                `ATM_OFF_CLOCK: rd.data <= 32'(clock_enable_bit);
                default: rd.data <= 32'h0000_0000;
            endcase
        end else if (rvalid && S_AXI_RREADY) begin
            rvalid <= 1'b0;
        end
    end

endmodule : atm_status_irq

`default_nettype wire
